// *** hdl/bwc_pkg.sv ***
/*
 * bwc_pkg: shared constants and types of the beam weight control block.
 * assumes: one 125 MHz clock for both ends, asynchronous active-low reset.
 */
package bwc_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int N_CH     = 16;
    localparam int N_BEAMS  = 256;
    localparam int AW       = 8;
    localparam int DW       = 8;
    localparam int VM_MAG_W = 6;
    localparam int VM_CTL_W = 7;
    localparam int PHASE_W  = 14;
    localparam int GAIN_W   = 6;
    localparam int CGAIN_W  = 5;
    localparam int LOAD_TOGGLES = 3;
    localparam logic [1:0] LOAD_LAST = 2'h2;

    // ------------------------------------------------------------
    // register map (device side, 8-bit index)
    // ------------------------------------------------------------
    localparam logic [AW-1:0] ADDR_TX_GAIN_CFG = 8'h2B;
    localparam logic [AW-1:0] ADDR_PDET_FIRST  = 8'h40;
    localparam logic [AW-1:0] ADDR_PDET_LAST   = 8'h4F;
    localparam logic [AW-1:0] ADDR_BEAM_SEL    = 8'h81;
    localparam logic [AW-1:0] ADDR_CTRL        = 8'h82;
    localparam logic [AW-1:0] ADDR_PDET_RANGE  = 8'h83;
    localparam logic [AW-1:0] ADDR_BYP_CH      = 8'h84;
    localparam logic [AW-1:0] ADDR_BYP_I       = 8'h85;
    localparam logic [AW-1:0] ADDR_BYP_Q       = 8'h86;
    localparam logic [AW-1:0] ADDR_BYP_GAIN    = 8'h87;
    localparam logic [AW-1:0] ADDR_MEM_BEAM    = 8'h88;
    localparam logic [AW-1:0] ADDR_MEM_WRITE   = 8'h89;
    localparam logic [AW-1:0] ADDR_CH_SEL_LO   = 8'h8A;
    localparam logic [AW-1:0] ADDR_CH_SEL_HI   = 8'h8B;
    localparam logic [AW-1:0] ADDR_STATUS      = 8'h8C;

    // field positions
    localparam int TXG_SWAP_BIT = 0;
    localparam int TXG_OFS_LSB  = 1;
    localparam int CTRL_BYPASS_BIT = 0;
    localparam int PDR_MAX_CODE = 14;   // -12..+16 dBm in 2 dBm steps
    localparam int VM_SIGN_BIT  = 6;

    localparam logic [DW-1:0] RESET_ZERO = 8'h00;
    localparam logic [DW-1:0] READ_UNMAPPED = 8'h00;

    // timing: select pin no faster than 1.5 MHz square wave, 70 ns settle
    localparam real CLK_NS       = 8.0;
    localparam real TRX_HALF_NS  = 333.4;
    localparam real TRX_SETTLE_NS = 70.0;
    localparam int  TRX_HALF_CYC = int'($ceil(TRX_HALF_NS / CLK_NS));
    localparam int  TRX_SETTLE_CYC = int'($ceil(TRX_SETTLE_NS / CLK_NS));

    typedef struct packed {
        logic [VM_CTL_W-1:0] i_ctl;
        logic [VM_CTL_W-1:0] q_ctl;
    } bwc_phase_t;

    typedef struct packed {
        bwc_phase_t        phase;
        logic [GAIN_W-1:0] gain;
    } bwc_weight_t;
endpackage

// *** hdl/bwc_if.sv ***
/*
 * bwc_if: the pins between the host controller and the beamformer control.
 * assumes: both ends share clk; pins are plain one-way levels.
 */
`timescale 1ns/100ps
`default_nettype none
interface bwc_if;
    import bwc_pkg::*;
    logic          load_strobe;
    logic          horiz_path_select;
    logic          vert_path_select;
    logic          reg_wr;
    logic          reg_rd;
    logic [AW-1:0] reg_addr;
    logic [DW-1:0] reg_wdata;
    logic [DW-1:0] reg_rdata;

    modport device (input load_strobe, horiz_path_select, vert_path_select,
                    reg_wr, reg_rd, reg_addr, reg_wdata, output reg_rdata);
    modport host   (output load_strobe, horiz_path_select, vert_path_select,
                    reg_wr, reg_rd, reg_addr, reg_wdata, input reg_rdata);
endinterface
`default_nettype wire

// *** hdl/bwc_device.sv ***
/*
 * bwc_device: weight memory, staging, three-toggle load, per-path
 * transmit/receive switching and power detector readback.
 * assumes: registers are reached over the interface port (read data one
 * cycle after the strobe); pins share the device clock and are still synced.
 */
`timescale 1ns/100ps
`default_nettype none
module bwc_device
    import bwc_pkg::*;
(
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    // link to host
    bwc_if.device                           link,
    // analog-facing controls
    output logic [N_CH-1:0][PHASE_W-1:0]    vm_phase,
    output logic [N_CH-1:0][GAIN_W-1:0]     first_tx_gain_stage,
    output logic [N_CH-1:0][GAIN_W-1:0]     second_tx_gain_stage,
    output logic [N_CH-1:0][GAIN_W-1:0]     rx_gain_stage,
    output logic [N_CH-1:0]                 ch_tx_mode,
    output logic [3:0]                      pdet_range,
    // detector results from converter
    input  wire logic [N_CH-1:0][DW-1:0]    pdet_code
);
    import bwc_pkg::*;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    bwc_weight_t                mem_r [N_BEAMS];
    bwc_weight_t [N_CH-1:0]     staged_r;
    bwc_weight_t [N_CH-1:0]     active_r;
    logic [CGAIN_W-1:0]         cgain_r [N_CH];
    logic [DW-1:0]              tx_gain_cfg_r;
    logic [DW-1:0]              beam_sel_r;
    logic                       bypass_r;
    logic [3:0]                 pdet_range_r;
    logic [3:0]                 byp_ch_r;
    logic [VM_CTL_W-1:0]        byp_i_r;
    logic [VM_CTL_W-1:0]        byp_q_r;
    logic [GAIN_W-1:0]          byp_gain_r;
    logic [DW-1:0]              mem_beam_r;
    logic [N_CH-1:0]            ch_sel_r;
    logic [1:0]                 load_cnt_r;
    logic [2:0]                 ld_sync_r;
    logic [2:0]                 h_sync_r;
    logic [2:0]                 v_sync_r;
    logic                       ld_state_r;
    logic                       h_tx_r;
    logic                       v_tx_r;
    logic [DW-1:0]              rdata_r;
    logic                       apply;

    function automatic bwc_weight_t pack_w(input logic [VM_CTL_W-1:0] i,
                                           input logic [VM_CTL_W-1:0] q,
                                           input logic [GAIN_W-1:0] g);
        bwc_weight_t w;
        w.phase.i_ctl = i;   // bit 6 sign, bits 5:0 magnitude
        w.phase.q_ctl = q;
        w.gain        = g;
        return w;
    endfunction

    function automatic logic wr_at(input logic [AW-1:0] a);
        return link.reg_wr && (link.reg_addr == a);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers: a change counts once stages 2 and 3 agree
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ld_sync_r <= 3'h0;
            h_sync_r  <= 3'h0;   // pins held low: start in receive
            v_sync_r  <= 3'h0;
        end else begin
            ld_sync_r <= {ld_sync_r[1:0], link.load_strobe};
            h_sync_r  <= {h_sync_r[1:0], link.horiz_path_select};
            v_sync_r  <= {v_sync_r[1:0], link.vert_path_select};
        end
    end

    // ------------------------------------------------------------
    // path modes, one per polarisation
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            h_tx_r <= 1'b0;
            v_tx_r <= 1'b0;
        end else begin
            // each path follows only its own pin edges
            if (h_sync_r[2] == h_sync_r[1])
                h_tx_r <= h_sync_r[2];
            if (v_sync_r[2] == v_sync_r[1])
                v_tx_r <= v_sync_r[2];
        end
    end

    // ------------------------------------------------------------
    // load strobe: count three toggles, then apply and restart
    // ------------------------------------------------------------
    assign apply = (ld_sync_r[2] == ld_sync_r[1]) && (ld_sync_r[2] != ld_state_r)
                   && (load_cnt_r == LOAD_LAST);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ld_state_r <= 1'b0;
            load_cnt_r <= 2'h0;
        end else if (ld_sync_r[2] == ld_sync_r[1] && ld_sync_r[2] != ld_state_r) begin
            ld_state_r <= ld_sync_r[2];
            if (load_cnt_r == LOAD_LAST)
                load_cnt_r <= 2'h0;
            else
                load_cnt_r <= load_cnt_r + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            active_r <= '0;
        end else if (apply) begin
            for (int c = 0; c < N_CH; c++) begin
                if (ch_sel_r[c])
                    active_r[c] <= staged_r[c];             // all selected channels at once
            end
        end
    end

    // ------------------------------------------------------------
    // weight memory and staging
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        // beam memory writes: one weight slot per beam, shared by every channel
        if (wr_at(ADDR_MEM_WRITE))
            mem_r[mem_beam_r] <= pack_w(byp_i_r, byp_q_r, byp_gain_r);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            staged_r <= '0;
        end else if (wr_at(ADDR_BEAM_SEL) && !bypass_r) begin
            // stage the selected beam for every channel
            for (int c = 0; c < N_CH; c++)
                staged_r[c] <= mem_r[link.reg_wdata];
        end else if (wr_at(ADDR_MEM_WRITE) && bypass_r) begin
            // direct per-channel write, held until load
            staged_r[byp_ch_r] <= pack_w(byp_i_r, byp_q_r, byp_gain_r);
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_gain_cfg_r <= RESET_ZERO;
            beam_sel_r    <= RESET_ZERO;
            bypass_r      <= 1'b0;
            pdet_range_r  <= 4'h0;
            byp_ch_r      <= 4'h0;
            byp_i_r       <= 7'h00;
            byp_q_r       <= 7'h00;
            byp_gain_r    <= 6'h00;
            mem_beam_r    <= RESET_ZERO;
            ch_sel_r      <= 16'hFFFF;
            for (int c = 0; c < N_CH; c++)
                cgain_r[c] <= 5'h00;
        end else if (link.reg_wr) begin
            case (link.reg_addr)
                ADDR_TX_GAIN_CFG: begin
                    tx_gain_cfg_r <= link.reg_wdata;
                    cgain_r[byp_ch_r] <= link.reg_wdata[TXG_OFS_LSB +: CGAIN_W];
                end
                ADDR_BEAM_SEL:   beam_sel_r <= link.reg_wdata;
                ADDR_CTRL:       bypass_r   <= link.reg_wdata[CTRL_BYPASS_BIT];
                ADDR_PDET_RANGE: begin
                    if (link.reg_wdata <= DW'(PDR_MAX_CODE))
                        pdet_range_r <= link.reg_wdata[3:0];
                end
                ADDR_BYP_CH:     byp_ch_r   <= link.reg_wdata[3:0];
                ADDR_BYP_I:      byp_i_r    <= link.reg_wdata[VM_CTL_W-1:0];
                ADDR_BYP_Q:      byp_q_r    <= link.reg_wdata[VM_CTL_W-1:0];
                ADDR_BYP_GAIN:   byp_gain_r <= link.reg_wdata[GAIN_W-1:0];
                ADDR_MEM_BEAM:   mem_beam_r <= link.reg_wdata;
                ADDR_CH_SEL_LO:  ch_sel_r[7:0]  <= link.reg_wdata;
                ADDR_CH_SEL_HI:  ch_sel_r[15:8] <= link.reg_wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // readback: data one cycle after the read strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= RESET_ZERO;
        end else if (link.reg_rd) begin
            if (link.reg_addr >= ADDR_PDET_FIRST && link.reg_addr <= ADDR_PDET_LAST) begin
                // valid only while the channel's path transmits
                rdata_r <= ch_tx_mode[link.reg_addr[3:0]] ?
                           pdet_code[link.reg_addr[3:0]] : READ_UNMAPPED;
            end else begin
                case (link.reg_addr)
                    ADDR_TX_GAIN_CFG: rdata_r <= tx_gain_cfg_r;
                    ADDR_BEAM_SEL:    rdata_r <= beam_sel_r;
                    ADDR_CTRL:        rdata_r <= {7'h00, bypass_r};
                    ADDR_PDET_RANGE:  rdata_r <= {4'h0, pdet_range_r};
                    ADDR_CH_SEL_LO:   rdata_r <= ch_sel_r[7:0];
                    ADDR_CH_SEL_HI:   rdata_r <= ch_sel_r[15:8];
                    ADDR_STATUS:      rdata_r <= {4'h0, load_cnt_r, v_tx_r, h_tx_r};
                    default:          rdata_r <= READ_UNMAPPED;
                endcase
            end
        end
    end
    assign link.reg_rdata = rdata_r;

    // ------------------------------------------------------------
    // analog-facing outputs, registered
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            vm_phase             <= '0;
            first_tx_gain_stage  <= '0;
            second_tx_gain_stage <= '0;
            rx_gain_stage        <= '0;
            ch_tx_mode           <= '0;
            pdet_range           <= 4'h0;
        end else begin
            pdet_range <= pdet_range_r;
            for (int c = 0; c < N_CH; c++) begin
                // mode follows pins; both weight sets stay in place
                ch_tx_mode[c] <= c[0] ? h_tx_r : v_tx_r;
                vm_phase[c]   <= active_r[c].phase;
                // rx stage from channel code alone, 0.5 dB per step
                rx_gain_stage[c] <= active_r[c].gain;
                // swap bit chooses which stage takes which code
                // common code is 1.0 dB per step, after channel while swap is clear
                if (tx_gain_cfg_r[TXG_SWAP_BIT]) begin
                    first_tx_gain_stage[c]  <= {1'b0, cgain_r[c]};
                    second_tx_gain_stage[c] <= active_r[c].gain;
                end else begin
                    first_tx_gain_stage[c]  <= active_r[c].gain;
                    second_tx_gain_stage[c] <= {1'b0, cgain_r[c]};
                end
            end
        end
    end
endmodule // bwc_device
`default_nettype wire

// *** hdl/bwc_host.sv ***
/*
 * bwc_host: host controller end; drives the register port, the load
 * strobe and both path select pins from simple user commands.
 * assumes: same clock as the device end; one command at a time.
 */
`timescale 1ns/100ps
`default_nettype none
module bwc_host
    import bwc_pkg::*;
(
    // clock and reset
    input  wire logic           clk,
    input  wire logic           reset_n,
    // user register access
    input  wire logic           cmd_wr,
    input  wire logic           cmd_rd,
    input  wire logic [AW-1:0]  cmd_addr,
    input  wire logic [DW-1:0]  cmd_wdata,
    output logic [DW-1:0]       cmd_rdata,
    output logic                cmd_rvalid,
    // user pin commands
    input  wire logic           cmd_load,
    input  wire logic           cmd_horiz_tx,
    input  wire logic           cmd_vert_tx,
    output logic                busy,
    // link to device
    bwc_if.host                 link
);
    import bwc_pkg::*;

    typedef enum logic [1:0] {H_IDLE, H_TOGGLE, H_GAP} bwc_ld_st_t;
    bwc_ld_st_t  ld_st_r;
    logic [1:0]  tog_cnt_r;
    logic [7:0]  gap_r;
    logic [7:0]  h_gap_r;
    logic [7:0]  v_gap_r;
    logic        rd_d_r;

    // ------------------------------------------------------------
    // register port: strobes registered one cycle, a write masking a read in the same cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            link.reg_wr    <= 1'b0;
            link.reg_rd    <= 1'b0;
            link.reg_addr  <= 8'h00;
            link.reg_wdata <= 8'h00;
            rd_d_r         <= 1'b0;
            cmd_rvalid     <= 1'b0;
            cmd_rdata      <= 8'h00;
        end else begin
            link.reg_wr    <= cmd_wr;
            link.reg_rd    <= cmd_rd & ~cmd_wr;
            link.reg_addr  <= cmd_addr;
            link.reg_wdata <= cmd_wdata;
            rd_d_r         <= link.reg_rd;
            cmd_rvalid     <= rd_d_r;
            if (rd_d_r)
                cmd_rdata <= link.reg_rdata;
        end
    end

    // ------------------------------------------------------------
    // load strobe: three toggles spaced so each is seen by the sync
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ld_st_r          <= H_IDLE;
            tog_cnt_r        <= 2'h0;
            gap_r            <= 8'h00;
            link.load_strobe <= 1'b0;
        end else begin
            case (ld_st_r)
                H_IDLE: if (cmd_load) begin
                    tog_cnt_r <= 2'h0;
                    ld_st_r   <= H_TOGGLE;
                end
                H_TOGGLE: begin
                    link.load_strobe <= ~link.load_strobe;
                    tog_cnt_r        <= tog_cnt_r + 2'h1;
                    gap_r            <= 8'(TRX_SETTLE_CYC);
                    ld_st_r          <= H_GAP;
                end
                H_GAP: begin
                    if (gap_r != 8'h00)
                        gap_r <= gap_r - 8'h01;
                    else if (tog_cnt_r == 2'(LOAD_TOGGLES))
                        ld_st_r <= H_IDLE;
                    else
                        ld_st_r <= H_TOGGLE;
                end
                default: ld_st_r <= H_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // path selects: low from reset, each limited to a half period
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            link.horiz_path_select <= 1'b0;
            link.vert_path_select  <= 1'b0;
            h_gap_r <= 8'h00;
            v_gap_r <= 8'h00;
        end else begin
            // no edge sooner than half of a 1.5 MHz period
            if (h_gap_r != 8'h00)
                h_gap_r <= h_gap_r - 8'h01;
            else if (cmd_horiz_tx != link.horiz_path_select) begin
                link.horiz_path_select <= cmd_horiz_tx;
                h_gap_r <= 8'(TRX_HALF_CYC);
            end
            if (v_gap_r != 8'h00)
                v_gap_r <= v_gap_r - 8'h01;
            else if (cmd_vert_tx != link.vert_path_select) begin
                link.vert_path_select <= cmd_vert_tx;
                v_gap_r <= 8'(TRX_HALF_CYC);
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            busy <= 1'b0;
        else
            busy <= (ld_st_r != H_IDLE) || cmd_load;
    end
endmodule // bwc_host
`default_nettype wire

// *** tb/bwc_asserts.sv ***
/* bwc_asserts: checks on the link between host end and device end.
   assumes: instantiated beside the interface; one clock, async low reset. */
`timescale 1ns/100ps
`default_nettype none
module bwc_asserts
    import bwc_pkg::*;
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          reset_n,
    // link signals
    input  wire logic          load_strobe,
    input  wire logic          horiz_path_select,
    input  wire logic          vert_path_select,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    input  wire logic [AW-1:0] reg_addr,
    input  wire logic [DW-1:0] reg_wdata,
    input  wire logic [DW-1:0] reg_rdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [7:0] h_gap_r;
    logic [7:0] v_gap_r;
    logic [7:0] l_gap_r;
    logic [7:0] rx_cnt_r;
    function automatic logic [7:0] sat(input logic [7:0] x);
        return (x == 8'hFF) ? x : x + 8'h01;
    endfunction
    // gaps start saturated so the first edge after reset is not judged
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            h_gap_r  <= 8'hFF;
            v_gap_r  <= 8'hFF;
            l_gap_r  <= 8'hFF;
            rx_cnt_r <= 8'h00;
        end else begin
            h_gap_r  <= $changed(horiz_path_select) ? 8'h00 : sat(h_gap_r);
            v_gap_r  <= $changed(vert_path_select) ? 8'h00 : sat(v_gap_r);
            l_gap_r  <= $changed(load_strobe) ? 8'h00 : sat(l_gap_r);
            rx_cnt_r <= (horiz_path_select || vert_path_select) ? 8'h00 : sat(rx_cnt_r);
        end
    end
    sequence s_rd(a);
        reg_rd && reg_addr == a;
    endsequence
    property p_strobe_excl;   !(reg_wr && reg_rd);   endproperty
    property p_rdata_stands;  !reg_rd |=> $stable(reg_rdata);   endproperty
    property p_sel_low;       $rose(reset_n) |-> !horiz_path_select && !vert_path_select;   endproperty
    property p_horiz_gap;     $changed(horiz_path_select) |-> h_gap_r >= TRX_HALF_CYC - 1;   endproperty
    property p_vert_gap;      $changed(vert_path_select) |-> v_gap_r >= TRX_HALF_CYC - 1;   endproperty
    property p_load_gap;      $changed(load_strobe) |-> l_gap_r >= TRX_SETTLE_CYC + 1;   endproperty
    property p_unmapped;      s_rd(8'h00) |=> reg_rdata == READ_UNMAPPED;   endproperty
    property p_pdet_rx_zero;
        reg_rd && reg_addr >= ADDR_PDET_FIRST && reg_addr <= ADDR_PDET_LAST && rx_cnt_r >= 8'h08
            |=> reg_rdata == RESET_ZERO;
    endproperty
    property p_reg_rw(a);
        logic [DW-1:0] v;
        (reg_wr && reg_addr == a, v = reg_wdata) ##[1:12] s_rd(a) |=> reg_rdata == v;
    endproperty
    a_strobe_excl:  assert property (p_strobe_excl) else $error("read and write strobes together");
    a_rdata_stands: assert property (p_rdata_stands) else $error("read data moved without a read");
    a_sel_low:      assert property (p_sel_low) else $error("select pin high after reset");
    a_horiz_gap:    assert property (p_horiz_gap) else $error("horizontal select too fast");
    a_vert_gap:     assert property (p_vert_gap) else $error("vertical select too fast");
    a_load_gap:     assert property (p_load_gap) else $error("load toggles too close");
    a_unmapped:     assert property (p_unmapped) else $error("unmapped read not zero");
    a_pdet_rx_zero: assert property (p_pdet_rx_zero) else $error("detector read in receive");
    a_txg_rw:       assert property (p_reg_rw(ADDR_TX_GAIN_CFG)) else $error("gain config readback");
    a_beam_rw:      assert property (p_reg_rw(ADDR_BEAM_SEL)) else $error("beam pointer readback");
endmodule // bwc_asserts
`default_nettype wire

// *** tb/bwc_tb.sv ***
/* bwc_tb: host end and device end joined by the interface, driven from the
   host user port; assumes both ends share one 125 MHz clock. */
`timescale 1ns/100ps
`default_nettype none
module bwc_tb;
    import bwc_pkg::*;
    logic                             clk, reset_n, busy, cmd_rvalid;
    logic                             cmd_wr, cmd_rd, cmd_load, cmd_horiz_tx, cmd_vert_tx;
    logic [AW-1:0]                    cmd_addr;
    logic [DW-1:0]                    cmd_wdata, cmd_rdata;
    logic [N_CH-1:0][PHASE_W-1:0]     vm_phase;
    logic [N_CH-1:0][GAIN_W-1:0]      first_tx, second_tx, rx_gain;
    logic [N_CH-1:0]                  ch_tx_mode;
    logic [3:0]                       pdet_range;
    logic [N_CH-1:0][DW-1:0]          pdet_code;
    int                               mismatches, samples_checked, i;
    bwc_if link();
    bwc_host u_bwc_host (.clk(clk), .reset_n(reset_n), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
        .cmd_load(cmd_load), .cmd_horiz_tx(cmd_horiz_tx), .cmd_vert_tx(cmd_vert_tx), .busy(busy),
        .link(link));
    bwc_device u_bwc_device (.clk(clk), .reset_n(reset_n), .link(link), .vm_phase(vm_phase),
        .first_tx_gain_stage(first_tx), .second_tx_gain_stage(second_tx), .rx_gain_stage(rx_gain),
        .ch_tx_mode(ch_tx_mode), .pdet_range(pdet_range), .pdet_code(pdet_code));
    bwc_asserts u_bwc_asserts (.clk(clk), .reset_n(reset_n), .load_strobe(link.load_strobe),
        .horiz_path_select(link.horiz_path_select), .vert_path_select(link.vert_path_select),
        .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_addr(link.reg_addr),
        .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_wr <= 1'b1;
        @(posedge clk);
        cmd_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        int n;
        cmd_addr <= a;
        cmd_rd <= 1'b1;
        @(posedge clk);
        cmd_rd <= 1'b0;
        for (n = 0; n < 10 && cmd_rvalid !== 1'b1; n++) @(posedge clk);
        if (n == 10) begin
            check(16'h1, 16'h0);
            complete_run();
        end
        check(cmd_rdata, exp);
    endtask
    // the host owns toggle spacing, so its busy flag is waited on, then a fixed 60 cycles
    task automatic wait_idle();
        int n;
        @(posedge clk);
        @(posedge clk);
        for (n = 0; n < 300 && busy !== 1'b0; n++) @(posedge clk);
        if (n == 300) begin
            check(16'h1, 16'h0);
            complete_run();
        end
        repeat (60) @(posedge clk);
    endtask
    task automatic load();
        cmd_load <= 1'b1;
        @(posedge clk);
        cmd_load <= 1'b0;
        wait_idle();
    endtask
    task automatic mode(input logic h, input logic v, input logic [15:0] exp);
        cmd_horiz_tx <= h;
        cmd_vert_tx <= v;
        wait_idle();
        check(ch_tx_mode, exp);
    endtask
    task automatic stage(input logic [7:0] b, input logic [7:0] iq, input logic [7:0] q,
                         input logic [7:0] g);
        wr(ADDR_MEM_BEAM, b);
        wr(ADDR_BYP_I, iq);
        wr(ADDR_BYP_Q, q);
        wr(ADDR_BYP_GAIN, g);
        wr(ADDR_MEM_WRITE, 8'h01);
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        {reset_n, cmd_wr, cmd_rd, cmd_load, cmd_horiz_tx, cmd_vert_tx} = 6'h00;
        cmd_addr = 8'h00;
        cmd_wdata = 8'h00;
        mismatches = 0;
        samples_checked = 0;
        for (i = 0; i < N_CH; i++) pdet_code[i] = 8'h10 + 8'(i);
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd(ADDR_TX_GAIN_CFG, RESET_ZERO);
        rd(8'h00, READ_UNMAPPED);
        rd(ADDR_PDET_LAST, RESET_ZERO);
        stage(8'h03, 8'h41, 8'h05, 8'h2A);
        wr(ADDR_BYP_CH, 8'h00);
        wr(ADDR_TX_GAIN_CFG, 8'h0A);
        rd(ADDR_TX_GAIN_CFG, 8'h0A);
        wr(ADDR_BEAM_SEL, 8'h03);
        rd(ADDR_BEAM_SEL, 8'h03);
        repeat (30) @(posedge clk);
        check(vm_phase[3], 16'h0000);
        load();
        for (i = 0; i < N_CH; i++) begin
            check(vm_phase[i], 16'h2085);
            check(rx_gain[i], 16'h002A);
        end
        check(first_tx[0], 16'h002A);
        check(second_tx[0], 16'h0005);
        wr(ADDR_TX_GAIN_CFG, 8'h0B);
        load();
        check(first_tx[0], 16'h0005);
        check(second_tx[0], 16'h002A);
        stage(8'hFF, 8'h7F, 8'h3F, 8'h3F);
        wr(ADDR_CH_SEL_HI, 8'h7F);
        wr(ADDR_BEAM_SEL, 8'hFF);
        load();
        check(vm_phase[15], 16'h2085);
        wr(ADDR_CTRL, 8'h01);
        wr(ADDR_BYP_CH, 8'h05);
        stage(8'h00, 8'h22, 8'h11, 8'h07);
        load();
        check(vm_phase[5], 16'h1111);
        check(vm_phase[4], 16'h3FBF);
        wr(ADDR_PDET_RANGE, 8'h0E);
        wr(ADDR_PDET_RANGE, 8'h0F);
        repeat (4) @(posedge clk);
        check(pdet_range, 16'h000E);
        mode(1'b1, 1'b0, 16'hAAAA);
        rd(8'h41, 8'h11);
        rd(ADDR_PDET_FIRST, RESET_ZERO);
        mode(1'b1, 1'b1, 16'hFFFF);
        rd(8'h4E, 8'h1E);
        mode(1'b0, 1'b1, 16'h5555);
        rd(8'h41, RESET_ZERO);
        mode(1'b0, 1'b0, 16'h0000);
        check(vm_phase[5], 16'h1111);
        complete_run();
    end
endmodule // bwc_tb
`default_nettype wire
